// [logic/dsf_map.svh]
// constants for the drive status flag block
`ifndef DSF_MAP_SVH
`define DSF_MAP_SVH

// ----------------------------------------------------------------
// speed thresholds (r/min, or mm/s for a linear motor)
// ----------------------------------------------------------------
`define DSF_ZS_LEVEL_RST     16'd50
`define DSF_ZS_HYST          16'd20
`define DSF_SPEED_W          16

// ----------------------------------------------------------------
// power-on settling window for the warning flags
// ----------------------------------------------------------------
`define DSF_CLK_HZ           10000000
`define DSF_SETTLE_MIN_MS    2500
`define DSF_SETTLE_MAX_MS    3500
`define DSF_SETTLE_MS        3000
`define DSF_SETTLE_CYC       ((`DSF_CLK_HZ / 1000) * `DSF_SETTLE_MS)

// ----------------------------------------------------------------
// control mode encodings
// ----------------------------------------------------------------
`define DSF_MODE_POS         2'h0
`define DSF_MODE_SPD         2'h1
`define DSF_MODE_TRQ         2'h2

`endif

// [logic/dsf_pkg.sv]
// types shared by the drive status flag block
package dsf_pkg;

    typedef enum logic [1:0] {
        DSF_POS   = 2'b00,
        DSF_SPD   = 2'b01,
        DSF_TRQ   = 2'b10,
        DSF_RSVD  = 2'b11
    } dsf_mode_type;

    // drive state sampled by the flag logic
    typedef struct packed {
        logic servo_on;
        logic torque_at_limit;
        logic warning_active;
        logic battery_cable_warning;
        logic battery_low_warning;
        logic variable_gain;
        logic abs_pos_undetermined;
        logic ride_through_active;
        logic closed_loop_active;
    } dsf_state_type;

    // flags presented to the machine controller
    typedef struct packed {
        logic zero_speed_flag;
        logic torque_limit_flag;
        logic warning_flag;
        logic battery_warning_flag;
        logic gain_switch_flag;
        logic abs_pos_unknown_flag;
        logic ride_through_flag;
        logic closed_loop_flag;
    } dsf_flags_type;

endpackage

// [logic/dsf_zero_speed.sv]
// zero-speed detector with fixed hysteresis in both directions
`timescale 1ns/1ns
`default_nettype none
`include "dsf_map.svh"

module dsf_zero_speed #(
    parameter int SPEED_W = `DSF_SPEED_W
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // speed and threshold
    input  wire logic signed [SPEED_W-1:0] speed,
    input  wire logic [SPEED_W-1:0]   zs_level,
    // result
    output logic                      zero_speed
);

    // elaboration-time refusal of widths the magnitude logic cannot serve
    if (SPEED_W < 8 || SPEED_W > 31) begin : g_bad_width
        $error("dsf_zero_speed: SPEED_W out of range");
    end

    logic [SPEED_W:0] mag;
    logic [SPEED_W:0] on_lvl;
    logic [SPEED_W:0] off_lvl;
    logic             zs_r;

    // magnitude widened one bit so the most negative speed cannot overflow
    assign mag     = speed[SPEED_W-1] ? (SPEED_W+1)'(-{speed[SPEED_W-1], speed})
                                      : {1'b0, speed};
    assign on_lvl  = {1'b0, zs_level};
    assign off_lvl = on_lvl + (SPEED_W+1)'(`DSF_ZS_HYST);

    // magnitude compare covers forward and reverse alike
    always_ff @(posedge clk) begin
        if (rst) begin
            zs_r <= 1'b0;
        end else if (mag <= on_lvl) begin
            zs_r <= 1'b1;
        end else if (mag >= off_lvl) begin
            zs_r <= 1'b0;
        end
    end

    assign zero_speed = zs_r;

endmodule
`default_nettype wire

// [logic/dsf_settle_timer.sv]
// power-on settling timer for the warning flags
`timescale 1ns/1ns
`default_nettype none
`include "dsf_map.svh"

module dsf_settle_timer #(
    parameter int SETTLE_CYC = `DSF_SETTLE_CYC
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // high once settling is over
    output logic      settled
);

    // a zero-length window would leave the counter compare unreachable
    if (SETTLE_CYC < 1) begin : g_bad_settle
        $error("dsf_settle_timer: SETTLE_CYC must be at least 1");
    end

    localparam int CW = $clog2(SETTLE_CYC + 1);

    logic [CW-1:0] cnt_r;
    logic          settled_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (!settled_r) begin
            cnt_r <= cnt_r + CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            settled_r <= 1'b0;
        end else if (cnt_r == CW'(SETTLE_CYC - 1)) begin
            settled_r <= 1'b1;
        end
    end

    assign settled = settled_r;

endmodule
`default_nettype wire

// [logic/dsf_status_flags.sv]
// drive status flag generator: top module
`timescale 1ns/1ns
`default_nettype none
`include "dsf_map.svh"

// Summary of operation
// - zero-speed flag on when speed magnitude is at or below the level
// - zero-speed level comes from a configurable parameter input
// - forward direction: flag stays on until speed climbs back to 70
// - reverse direction: same on/off points mirrored, -50 and -70
// - fixed hysteresis of 20 between on and off levels
// - for a linear motor all units read as mm/s, logic unchanged
// - torque-limit flag on when torque reaches its limit
// - torque-limit flag forced off while servo is off
// - torque-limit flag not provided in torque control mode
// - warning flag on while any warning is present
// - warning flag held on after power-on, dropped within 2.5 to 3.5 s
// - battery flag on for battery cable or battery low warning
// - battery flag held on after power-on, dropped within 2.5 to 3.5 s
// - gain-switch flag on while variable gain is in effect
// - absolute-position flag on while position is undetermined
// - absolute-position flag not provided in speed or torque mode
// - ride-through flag on while enabled and ride-through active
// - closed-loop flag on while fully closed loop control is active
module dsf_status_flags
    import dsf_pkg::*;
#(
    parameter int SPEED_W    = `DSF_SPEED_W,
    parameter int SETTLE_CYC = `DSF_SETTLE_CYC
) (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst,
    // motor speed, signed, same units as the level
    input  wire logic signed [SPEED_W-1:0] motor_speed,
    // configuration
    input  wire logic [SPEED_W-1:0]        zero_speed_level_param,
    input  wire logic                      ride_through_enable_param,
    input  wire dsf_pkg::dsf_mode_type     control_mode,
    // internal drive state
    input  wire dsf_pkg::dsf_state_type    drive_state,
    // status flags
    output dsf_pkg::dsf_flags_type         flags
);
    import dsf_pkg::*;

    // elaboration-time refusal of widths the detector cannot serve
    if (SPEED_W < 8 || SPEED_W > 31) begin : g_bad_width
        $error("dsf_status_flags: SPEED_W out of range");
    end

    // ----------------------------------------------------------------
    // zero speed
    // ----------------------------------------------------------------
    // units follow the motor type; nothing in here depends on them
    logic zs;

    dsf_zero_speed #(
        .SPEED_W (SPEED_W)
    ) u_zero_speed (
        .clk        (clk),
        .rst        (rst),
        .speed      (motor_speed),
        .zs_level   (zero_speed_level_param),
        .zero_speed (zs)
    );

    // ----------------------------------------------------------------
    // power-on settling
    // ----------------------------------------------------------------
    logic settled;

    dsf_settle_timer #(
        .SETTLE_CYC (SETTLE_CYC)
    ) u_settle (
        .clk     (clk),
        .rst     (rst),
        .settled (settled)
    );

    // ----------------------------------------------------------------
    // flag registers
    // ----------------------------------------------------------------
    // zero speed is one cycle behind the detector so the output is a flop
    dsf_flags_type flags_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            flags_r.zero_speed_flag <= 1'b0;
        end else begin
            flags_r.zero_speed_flag <= zs;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flags_r.torque_limit_flag <= 1'b0;
        end else begin
            flags_r.torque_limit_flag <= drive_state.torque_at_limit
                                       & drive_state.servo_on
                                       & (control_mode != DSF_TRQ);
        end
    end

    // warning flags read on through reset and settling, as power-on demands
    always_ff @(posedge clk) begin
        if (rst) begin
            flags_r.warning_flag <= 1'b1;
        end else begin
            flags_r.warning_flag <= drive_state.warning_active | !settled;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flags_r.battery_warning_flag <= 1'b1;
        end else begin
            flags_r.battery_warning_flag <= drive_state.battery_cable_warning
                                          | drive_state.battery_low_warning
                                          | !settled;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flags_r.gain_switch_flag <= 1'b0;
        end else begin
            flags_r.gain_switch_flag <= drive_state.variable_gain;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flags_r.abs_pos_unknown_flag <= 1'b0;
        end else begin
            flags_r.abs_pos_unknown_flag <= drive_state.abs_pos_undetermined
                                          & (control_mode != DSF_SPD)
                                          & (control_mode != DSF_TRQ);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flags_r.ride_through_flag <= 1'b0;
        end else begin
            flags_r.ride_through_flag <= ride_through_enable_param
                                       & drive_state.ride_through_active;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flags_r.closed_loop_flag <= 1'b0;
        end else begin
            flags_r.closed_loop_flag <= drive_state.closed_loop_active;
        end
    end

    assign flags = flags_r;

endmodule
`default_nettype wire

// [testbench/dsf_status_flags_monitor.sv]
// assertion checker for the status flag block
`timescale 1ns/1ns
`default_nettype none
module dsf_status_flags_monitor
    import dsf_pkg::*;
#(
    parameter int SPEED_W    = 16,
    parameter int SETTLE_CYC = 30
) (
    // watched ports
    input wire logic                      clk,
    input wire logic                      rst,
    input wire logic signed [SPEED_W-1:0] motor_speed,
    input wire logic [SPEED_W-1:0]        zero_speed_level_param,
    input wire logic                      ride_through_enable_param,
    input wire dsf_pkg::dsf_mode_type     control_mode,
    input wire dsf_pkg::dsf_state_type    drive_state,
    input wire dsf_pkg::dsf_flags_type    flags
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    int   v;
    int   lv;
    int   cnt_r;
    logic tl_c;
    logic abs_c;
    assign v = motor_speed;
    assign lv = int'(zero_speed_level_param);
    assign tl_c = drive_state.servo_on & drive_state.torque_at_limit & (control_mode != DSF_TRQ);
    assign abs_c = drive_state.abs_pos_undetermined & (control_mode inside {DSF_POS, DSF_RSVD});
    // saturates so the settle check stays cheap
    always_ff @(posedge clk) begin
        cnt_r <= rst ? 0 : (cnt_r < SETTLE_CYC ? cnt_r + 1 : cnt_r);
    end
    sequence s_low;  v <= lv && v >= -lv; endsequence
    sequence s_high; v >= lv + 20 || v <= -lv - 20; endsequence
    sequence s_mid;  (v > lv || v < -lv) && v < lv + 20 && v > -lv - 20; endsequence
    chk_zs_on: assert property (s_low |-> ##2 flags.zero_speed_flag)
        else $error("zero speed flag missing");
    chk_zs_off: assert property (s_high |-> ##2 !flags.zero_speed_flag)
        else $error("zero speed flag stuck");
    chk_zs_hold: assert property (s_mid |-> ##2 $stable(flags.zero_speed_flag))
        else $error("zero speed flag moved in band");
    chk_tl_cause: assert property (1'b1 |=> flags.torque_limit_flag == $past(tl_c))
        else $error("torque limit flag wrong");
    chk_warn_on: assert property (drive_state.warning_active |=> flags.warning_flag)
        else $error("warning flag missing");
    chk_batt_on: assert property (drive_state.battery_cable_warning
        || drive_state.battery_low_warning |=> flags.battery_warning_flag)
        else $error("battery flag missing");
    chk_abs_mode: assert property (1'b1 |=> flags.abs_pos_unknown_flag == $past(abs_c))
        else $error("abs position flag wrong");
    chk_ride_gate: assert property (!ride_through_enable_param |=> !flags.ride_through_flag)
        else $error("ride through flag while disabled");
    chk_settle_hold: assert property (cnt_r < SETTLE_CYC |-> flags.warning_flag
        && flags.battery_warning_flag) else $error("warning dropped early");
endmodule
bind dsf_status_flags dsf_status_flags_monitor #(.SPEED_W(SPEED_W), .SETTLE_CYC(SETTLE_CYC))
    u_mon (.clk(clk), .rst(rst), .motor_speed(motor_speed),
    .zero_speed_level_param(zero_speed_level_param),
    .ride_through_enable_param(ride_through_enable_param), .control_mode(control_mode),
    .drive_state(drive_state), .flags(flags));
`default_nettype wire

// [testbench/dsf_ctrl_model.sv]
// machine controller model: latches the status flags each clock
`timescale 1ns/1ns
`default_nettype none
module dsf_ctrl_model
    import dsf_pkg::*;
(
    input  wire logic                   clk,
    input  wire dsf_pkg::dsf_flags_type flags,
    output dsf_pkg::dsf_flags_type      rd_flags
);
    always_ff @(posedge clk) begin
        rd_flags <= flags;
    end
endmodule
`default_nettype wire

// [testbench/dsf_status_flags_test.sv]
// self-checking bench for the status flag block
`timescale 1ns/1ns
`default_nettype none
module dsf_status_flags_test;
    import dsf_pkg::*;
    localparam int SC = 30;
    // drop window is 2.5 s .. 3.5 s scaled so that 3.0 s maps to SC
    localparam int SMIN = SC * 25 / 30;
    localparam int SMAX = SC * 35 / 30;
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic signed [15:0] spd = 16'sh03e8;
    logic [15:0]        lvl = 16'h0032;
    logic               rt_en = 1'b1;
    dsf_mode_type       mode = DSF_POS;
    dsf_state_type      st = '0;
    dsf_flags_type      flags;
    dsf_flags_type      rd;
    dsf_flags_type      q[$];
    int                 qt[$];
    int                 cyc = 0;
    int                 miscompares = 0;
    int                 n_tests = 0;
    always #50 clk = ~clk;
    dsf_status_flags #(.SPEED_W(16), .SETTLE_CYC(SC)) i_dut (.clk(clk), .rst(rst),
        .motor_speed(spd), .zero_speed_level_param(lvl), .ride_through_enable_param(rt_en),
        .control_mode(mode), .drive_state(st), .flags(flags));
    dsf_ctrl_model i_ctrl (.clk(clk), .flags(flags), .rd_flags(rd));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // controller copy lags the inputs by two rising edges; notes fall due by age so none is left over
    always @(negedge clk) begin
        cyc++;
        if (qt.size() > 0 && cyc - qt[0] > 2) begin
            void'(qt.pop_front());
            chk(rd, q.pop_front());
        end
    end
    task automatic settle_chk;
        int n;
        n = 0;
        @(posedge clk);
        st <= '1;
        spd <= '0;
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk(flags, 8'h30);
        @(posedge clk);
        rst <= 1'b0;
        st <= '0;
        spd <= 16'sh03e8;
        while (flags.warning_flag !== 1'b0 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk(8'(n >= SMIN && n <= SMAX), 8'h01);
        chk(flags, 8'h00);
    endtask
    task automatic rand_run(input int cycles);
        int sv;
        int lv;
        int det;
        dsf_state_type s;
        dsf_mode_type m;
        logic e;
        sv = 0;
        lv = 50;
        det = 0;
        for (int i = 0; i < cycles; i++) begin
            @(posedge clk);
            sv = sv + $urandom_range(14) - 7;
            // restart at zero so the walk keeps crossing both levels
            if (sv > 140 || sv < -140) sv = 0;
            if (i % 64 == 0 && i >= 256) lv = $urandom_range(120);
            s = dsf_state_type'(9'($urandom_range(511)));
            m = dsf_mode_type'(2'($urandom_range(3)));
            e = 1'($urandom_range(1));
            spd <= 16'(sv);
            lvl <= 16'(lv);
            st <= s;
            mode <= m;
            rt_en <= e;
            qt.push_back(cyc);
            q.push_back(dsf_flags_type'({1'(det),
                s.servo_on & s.torque_at_limit & (m != DSF_TRQ),
                s.warning_active, s.battery_cable_warning | s.battery_low_warning,
                s.variable_gain, s.abs_pos_undetermined & (m != DSF_SPD) & (m != DSF_TRQ),
                e & s.ride_through_active, s.closed_loop_active}));
            if (sv <= lv && sv >= -lv) det = 1;
            else if (sv >= lv + 20 || sv <= -lv - 20) det = 0;
        end
    endtask
    initial begin
        void'($urandom(48832));
        settle_chk();
        rand_run(600);
        settle_chk();
        end_of_test();
    end
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        end_of_test();
    end
endmodule
`default_nettype wire
